/* verilog/irq_wake_ctrl.sv */
// Interrupt control: wake, pin edge, vectoring, context shadows and register bus.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.

// Function
// R1 - Software enables wake sources before sleeping.
// R2 - Wake vectors only when global enable set.
// R3 - One instruction runs after wake before vectoring.
// R4 - Pin gives edge request, gated by enable.
// R5 - Select one means rising, zero falling.
// R6 - Valid pin edge sets external flag.
// R7 - Flag with both enables redirects to vector.
// R8 - Entry pushes return address to stack.
// R9 - Entry copies context into shadows, status masked.
// R10 - Return reloads context from shadows.
// R11 - Shadows software readable and writable, restored.
// R12 - Control register layout and reset values.
// R13 - Peripheral enable and global enable gate requests.
module irq_wake_ctrl (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_irq_pin_i,
  input wire logic [irq_pkg::PERIPH_W-1:0] periph_req_i,
  input wire logic sleep_i,
  input wire logic instr_done_i,
  input wire logic entry_i,
  input wire logic return_i,
  input wire logic [irq_pkg::PC_W-1:0] ret_pc_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] bank_i,
  input wire logic [15:0] ptr_i,
  input wire logic [7:0] pch_i,
  output logic wake_o,
  output logic vector_req_o,
  output logic push_o,
  output logic [irq_pkg::PC_W-1:0] push_pc_o,
  output logic restore_o,
  output logic [7:0] sh_acc_o,
  output logic [7:0] sh_status_o,
  output logic [7:0] sh_bank_o,
  output logic [15:0] sh_ptr_o,
  output logic [7:0] sh_pch_o,
  output logic irq_o
);

  logic rst_meta_r; // First reset release stage.
  logic rst_n; // Released reset used by all logic.
  logic global_en_r; // global_irq_enable.
  logic periph_en_r; // peripheral_irq_enable.
  logic edge_sel_r; // ext_irq_edge_select.
  logic ext_en_r; // ext_irq_enable.
  logic ext_flag_r; // ext_irq_flag.
  logic [irq_pkg::EV_W-1:0] evt_r; // Sticky event status.
  logic [irq_pkg::EV_W-1:0] mask_r; // Event mask.
  logic [irq_pkg::EV_W-1:0] evt_set; // Events raised this cycle.
  irq_pkg::seq_state_t state_r; // Sequencer state.
  logic pending; // Some enabled request is waiting.
  logic bus_req; // A bus request is present.
  logic wr_go; // Write takes effect this edge.
  logic [7:0] wbyte; // Low byte of write data.
  logic [7:0] ctrl_rd; // Read view of interrupt_control.
  logic [31:0] rd_nxt; // Read data for the current address.
  pin_edge_if eif (); // Link to the pin edge detector.

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  assign eif.edge_sel = edge_sel_r;

  pin_edge_detect u_edge (
    .clk_i (sys_clk_i),
    .rst_n_i (rst_n),
    .pin_i (ext_irq_pin_i),
    .eif (eif.det)
  );

  // Pending request: external flag when enabled, peripherals behind their own enable.
  // Sources are assumed enabled by software before sleep; only those can wake.
  assign pending = (ext_flag_r && ext_en_r) || (periph_en_r && (|periph_req_i)); // R1 R4 R13

  assign bus_req = avs_read_i || avs_write_i;
  assign wr_go = avs_write_i && !avs_waitrequest_o;
  assign wbyte = avs_writedata_i[7:0];

  // Bus handshake: every access waits exactly one cycle, which gives read data
  // a full cycle to settle and keeps the output straight from a flip-flop.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  // Control register view; bits 5 to 1 read as zero.
  assign ctrl_rd = {global_en_r, periph_en_r, 5'h00, edge_sel_r}; // R12

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (avs_address_i == irq_pkg::ADDR_CTRL)
      rd_nxt[7:0] = ctrl_rd;
    else if (avs_address_i == irq_pkg::ADDR_EN0)
      rd_nxt[irq_pkg::EXT_EN_BIT] = ext_en_r;
    else if (avs_address_i == irq_pkg::ADDR_REQ0)
      rd_nxt[irq_pkg::EXT_FLAG_BIT] = ext_flag_r;
    else if (avs_address_i == irq_pkg::ADDR_EVT)
      rd_nxt[irq_pkg::EV_W-1:0] = evt_r;
    else if (avs_address_i == irq_pkg::ADDR_MASK)
      rd_nxt[irq_pkg::EV_W-1:0] = mask_r;
    else if (avs_address_i == irq_pkg::ADDR_SH_ACC)
      rd_nxt[7:0] = sh_acc_o; // R11
    else if (avs_address_i == irq_pkg::ADDR_SH_STAT)
      rd_nxt[7:0] = sh_status_o;
    else if (avs_address_i == irq_pkg::ADDR_SH_BANK)
      rd_nxt[7:0] = sh_bank_o;
    else if (avs_address_i == irq_pkg::ADDR_SH_PTR_LO)
      rd_nxt[7:0] = sh_ptr_o[7:0];
    else if (avs_address_i == irq_pkg::ADDR_SH_PTR_HI)
      rd_nxt[7:0] = sh_ptr_o[15:8];
    else if (avs_address_i == irq_pkg::ADDR_SH_PCH)
      rd_nxt[7:0] = sh_pch_o;
  end

  // Read data is captured on the edge that drops waitrequest and then holds.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (avs_read_i && avs_waitrequest_o)
    begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // Control bits. Hardware clears global enable on entry and sets it on return so
  // that a routine is not re-entered; both hardware actions win over a write.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_en_r <= irq_pkg::CTRL_RESET[irq_pkg::GLOBAL_EN_BIT]; // R12
      periph_en_r <= irq_pkg::CTRL_RESET[irq_pkg::PERIPH_EN_BIT];
      edge_sel_r <= irq_pkg::CTRL_RESET[irq_pkg::EDGE_BIT];
      ext_en_r <= 1'b0;
    end
    else
    begin
      if (wr_go && avs_address_i == irq_pkg::ADDR_CTRL)
      begin
        global_en_r <= wbyte[irq_pkg::GLOBAL_EN_BIT];
        periph_en_r <= wbyte[irq_pkg::PERIPH_EN_BIT];
        edge_sel_r <= wbyte[irq_pkg::EDGE_BIT];
      end
      else if (wr_go && avs_address_i == irq_pkg::ADDR_EN0)
      begin
        ext_en_r <= wbyte[irq_pkg::EXT_EN_BIT];
      end
      if (entry_i && state_r == irq_pkg::ST_RUN)
        global_en_r <= 1'b0;
      else if (return_i && state_r == irq_pkg::ST_SRV)
        global_en_r <= 1'b1;
    end
  end

  // External flag: set by any valid edge, even with the enable clear; software
  // clears it by writing zero, and an edge in that same cycle wins.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_flag_r <= 1'b0;
    end
    else if (eif.edge_pulse)
    begin
      ext_flag_r <= 1'b1; // R6
    end
    else if (wr_go && avs_address_i == irq_pkg::ADDR_REQ0)
    begin
      ext_flag_r <= wbyte[irq_pkg::EXT_FLAG_BIT];
    end
  end

  // Sequencer tracking the core: sleep, the one step after wake, and service.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= irq_pkg::ST_RUN;
    end
    else
    begin
      case (state_r)
        irq_pkg::ST_RUN:
          if (entry_i)
            state_r <= irq_pkg::ST_SRV;
          else if (sleep_i)
            state_r <= irq_pkg::ST_SLEEP;
        irq_pkg::ST_SLEEP:
          if (pending)
            state_r <= irq_pkg::ST_STEP; // R2
        irq_pkg::ST_STEP:
          if (instr_done_i)
            state_r <= irq_pkg::ST_RUN; // R3
        irq_pkg::ST_SRV:
          if (return_i)
            state_r <= irq_pkg::ST_RUN;
        default:
          state_r <= irq_pkg::ST_RUN;
      endcase
    end
  end

  // Wake pulse and vector request. Wake ignores the global enable; the vector
  // needs it, and waits in the step state for the post-sleep instruction.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_o <= 1'b0;
      vector_req_o <= 1'b0;
    end
    else
    begin
      wake_o <= (state_r == irq_pkg::ST_SLEEP) && pending; // R2
      vector_req_o <= (state_r == irq_pkg::ST_RUN) && global_en_r && pending && !entry_i; // R7 R13 R3
    end
  end

  // Return address push on entry.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_o <= 1'b0;
      push_pc_o <= '0;
      restore_o <= 1'b0;
    end
    else
    begin
      push_o <= entry_i && (state_r == irq_pkg::ST_RUN); // R8
      restore_o <= return_i && (state_r == irq_pkg::ST_SRV); // R10
      if (entry_i && state_r == irq_pkg::ST_RUN)
        push_pc_o <= ret_pc_i; // R8
    end
  end

  // Shadow registers: captured on entry, otherwise writable by software. The
  // core reloads from these outputs on restore_o, so software edits take effect.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_acc_o <= irq_pkg::BYTE_RESET;
      sh_status_o <= irq_pkg::BYTE_RESET;
      sh_bank_o <= irq_pkg::BYTE_RESET;
      sh_ptr_o <= {irq_pkg::BYTE_RESET, irq_pkg::BYTE_RESET};
      sh_pch_o <= irq_pkg::BYTE_RESET;
    end
    else if (entry_i && state_r == irq_pkg::ST_RUN)
    begin
      sh_acc_o <= acc_i; // R9
      sh_status_o <= status_i & irq_pkg::STATUS_SAVE_MASK; // R9
      sh_bank_o <= bank_i;
      sh_ptr_o <= ptr_i;
      sh_pch_o <= pch_i;
    end
    else if (wr_go)
    begin
      if (avs_address_i == irq_pkg::ADDR_SH_ACC)
        sh_acc_o <= wbyte; // R11
      else if (avs_address_i == irq_pkg::ADDR_SH_STAT)
        sh_status_o <= wbyte & irq_pkg::STATUS_SAVE_MASK;
      else if (avs_address_i == irq_pkg::ADDR_SH_BANK)
        sh_bank_o <= wbyte;
      else if (avs_address_i == irq_pkg::ADDR_SH_PTR_LO)
        sh_ptr_o[7:0] <= wbyte;
      else if (avs_address_i == irq_pkg::ADDR_SH_PTR_HI)
        sh_ptr_o[15:8] <= wbyte;
      else if (avs_address_i == irq_pkg::ADDR_SH_PCH)
        sh_pch_o <= wbyte;
    end
  end

  // Events raised this cycle, one bit per event.
  assign evt_set = {restore_o, push_o, wake_o, eif.edge_pulse};

  // Sticky event status with write-one-to-clear; a new event beats the clear.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_r <= irq_pkg::EVT_RESET;
      mask_r <= irq_pkg::EVT_RESET;
    end
    else
    begin
      if (wr_go && avs_address_i == irq_pkg::ADDR_EVT)
        evt_r <= (evt_r & ~wbyte[irq_pkg::EV_W-1:0]) | evt_set;
      else
        evt_r <= evt_r | evt_set;
      if (wr_go && avs_address_i == irq_pkg::ADDR_MASK)
        mask_r <= wbyte[irq_pkg::EV_W-1:0];
    end
  end

  // Level interrupt output, registered.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else
      irq_o <= |(evt_r & mask_r);
  end

  // Sequences for the wake path.
  sequence s_wake;
    (state_r == irq_pkg::ST_SLEEP) && pending;
  endsequence

  sequence s_step_done;
    (state_r == irq_pkg::ST_STEP) && instr_done_i;
  endsequence

  a_wake_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R2
    s_wake |=> wake_o && (state_r == irq_pkg::ST_STEP))
    else $error("Wake did not follow a pending request in sleep.");

  a_step_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R3
    s_wake |=> !vector_req_o ##1 !vector_req_o)
    else $error("Vector requested before the post-sleep instruction.");

  a_step_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R3
    s_step_done |=> (state_r == irq_pkg::ST_RUN))
    else $error("Step state not left after the instruction.");

  a_vector_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R7
    vector_req_o |-> $past(global_en_r) && $past(pending) && $past(state_r == irq_pkg::ST_RUN))
    else $error("Vector request without global enable and a request.");

  a_ext_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R7
    (state_r == irq_pkg::ST_RUN) && global_en_r && ext_flag_r && ext_en_r && !entry_i
    |=> vector_req_o)
    else $error("Enabled external flag did not request the vector.");

  a_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R6
    eif.edge_pulse |=> ext_flag_r && evt_r[irq_pkg::EV_EDGE])
    else $error("Pin edge did not set the external flag.");

  a_push_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R8
    entry_i && (state_r == irq_pkg::ST_RUN) |=> push_o && (push_pc_o == $past(ret_pc_i)))
    else $error("Return address not pushed on entry.");

  a_shadow_save: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R9
    entry_i && (state_r == irq_pkg::ST_RUN)
    |=> (sh_acc_o == $past(acc_i)) && (sh_ptr_o == $past(ptr_i))
    && (sh_status_o == ($past(status_i) & irq_pkg::STATUS_SAVE_MASK)))
    else $error("Context not copied into shadows on entry.");

  a_restore_ret: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R10
    return_i && (state_r == irq_pkg::ST_SRV) |=> restore_o && global_en_r)
    else $error("Return did not raise restore.");

  a_ctrl_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R12
    avs_read_i && avs_waitrequest_o && (avs_address_i == irq_pkg::ADDR_CTRL)
    |=> avs_readdata_o[5:1] == 5'h00)
    else $error("Unimplemented control bits read as nonzero.");

endmodule : irq_wake_ctrl

/* verilog/irq_pkg.sv */
// Constants, register map and state codes shared by the interrupt control files.
package irq_pkg;

  // Register byte addresses on the bus; each register takes one aligned word.
  localparam logic [5:0] ADDR_CTRL = 6'h00; // interrupt_control.
  localparam logic [5:0] ADDR_EN0 = 6'h04; // irq_enable_reg0.
  localparam logic [5:0] ADDR_REQ0 = 6'h08; // irq_request_reg0.
  localparam logic [5:0] ADDR_EVT = 6'h0c; // Sticky event status, write one to clear.
  localparam logic [5:0] ADDR_MASK = 6'h10; // Event mask, same layout as status.
  localparam logic [5:0] ADDR_SH_ACC = 6'h20; // Shadow accumulator (bank 31 view).
  localparam logic [5:0] ADDR_SH_STAT = 6'h24; // Shadow status.
  localparam logic [5:0] ADDR_SH_BANK = 6'h28; // Shadow bank_select.
  localparam logic [5:0] ADDR_SH_PTR_LO = 6'h2c; // Shadow indirect_pointer, low byte.
  localparam logic [5:0] ADDR_SH_PTR_HI = 6'h30; // Shadow indirect_pointer, high byte.
  localparam logic [5:0] ADDR_SH_PCH = 6'h34; // Shadow pc_high_latch.

  // Field positions.
  localparam int GLOBAL_EN_BIT = 7; // global_irq_enable in interrupt_control.
  localparam int PERIPH_EN_BIT = 6; // peripheral_irq_enable in interrupt_control.
  localparam int EDGE_BIT = 0; // ext_irq_edge_select in interrupt_control.
  localparam int EXT_EN_BIT = 0; // ext_irq_enable in irq_enable_reg0.
  localparam int EXT_FLAG_BIT = 0; // ext_irq_flag in irq_request_reg0.

  // Values after reset.
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] EVT_RESET = 4'h0;

  // Status bits that are never saved: watchdog_expired_flag and sleep_entered_flag.
  localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;

  // Event status bit positions.
  localparam int EV_EDGE = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_ENTRY = 2;
  localparam int EV_RETURN = 3;
  localparam int EV_W = 4;

  // Widths.
  localparam int PC_W = 15;
  localparam int PERIPH_W = 8;

  // Sequencer states, one-hot.
  typedef enum logic [3:0]
  {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_STEP = 4'h4,
    ST_SRV = 4'h8
  } seq_state_t;

endpackage : irq_pkg

/* verilog/pin_edge_if.sv */
// Carries the edge polarity select and the detected edge between the two modules.
interface pin_edge_if;
  logic edge_sel; // One selects rising edges, zero falling edges.
  logic edge_pulse; // One cycle per accepted edge of the selected polarity.
  modport det (input edge_sel, output edge_pulse);
  modport ctl (output edge_sel, input edge_pulse);
endinterface : pin_edge_if

/* verilog/pin_edge_detect.sv */
// Synchronises the external interrupt pin and detects its selected edge.
module pin_edge_detect (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  pin_edge_if.det eif
);

  logic s1_r; // First stage, read only by the second stage.
  logic s2_r; // Second stage.
  logic s3_r; // Third stage.
  logic lvl_r; // Last accepted settled level of the pin.
  logic settled; // Second and third stage agree.
  logic [2:0] fill_r; // Ones shift in after reset until every stage holds a pin sample.

  // Three-stage synchroniser; the pin is asynchronous to the system clock.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign settled = (s2_r == s3_r);

  // Fill marker. While the stages still hold reset values the level tracker just
  // copies the pin, so a pin that idles high gives no false edge after reset.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fill_r <= 3'h0;
    end
    else
    begin
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // Tracking the settled level, not the raw pin, means a change of the
  // polarity select can never itself look like an edge.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lvl_r <= 1'b0;
    end
    else if (settled || !fill_r[2])
    begin
      lvl_r <= s2_r;
    end
  end

  // An edge counts once the level settles on a new value that matches the select.
  assign eif.edge_pulse = settled && (s3_r != lvl_r) && (s3_r == eif.edge_sel); // R4 R5

  a_edge_polarity: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    eif.edge_pulse |-> (s3_r == eif.edge_sel) && ($past(s2_r) == s3_r) && (lvl_r != s3_r))
    else $error("Edge pulse does not match the selected polarity.");

endmodule : pin_edge_detect

/* bench/core_model.sv */
// Behavioural stand-in for the processor core sequencer on the far side of the block.
module core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wake_i,
  input wire logic vector_req_i,
  input wire logic [3:0] lag_i,
  input wire logic sleep_cmd_i,
  input wire logic ret_cmd_i,
  output logic sleep_o,
  output logic instr_done_o,
  output logic entry_o,
  output logic return_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stepping_r; // The instruction after sleep is still running.
  logic [3:0] step_cnt_r; // Cycles left on that instruction.
  logic [3:0] ent_cnt_r; // Cycles the core dawdles before taking the vector.
  logic in_srv_r; // The core is inside the service routine.

  // Sleep and return are commanded by the bench; sleep is relayed as is, return only while inside the service routine.
  assign sleep_o = sleep_cmd_i;
  assign return_o = ret_cmd_i & in_srv_r;

  // The lag input lets the bench make the core prompt or slow.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stepping_r <= 1'b0;
      step_cnt_r <= 4'h0;
      ent_cnt_r <= 4'h0;
      in_srv_r <= 1'b0;
      instr_done_o <= 1'b0;
      entry_o <= 1'b0;
    end
    else
    begin
      instr_done_o <= 1'b0;
      entry_o <= 1'b0;
      if (wake_i)
      begin
        stepping_r <= 1'b1;
        step_cnt_r <= lag_i;
      end
      else if (stepping_r && step_cnt_r == 4'h0)
      begin
        instr_done_o <= 1'b1;
        stepping_r <= 1'b0;
      end
      else if (stepping_r)
        step_cnt_r <= step_cnt_r - 4'h1;
      if (return_o)
        in_srv_r <= 1'b0;
      else if (vector_req_i && !in_srv_r && ent_cnt_r >= lag_i)
      begin
        entry_o <= 1'b1;
        in_srv_r <= 1'b1;
        ent_cnt_r <= 4'h0;
      end
      else if (vector_req_i && !in_srv_r)
        ent_cnt_r <= ent_cnt_r + 4'h1;
    end
  end
endmodule : core_model

/* bench/tb.sv */
// Self-checking bench for the interrupt wake and context save block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn;
  logic [5:0] addr;
  logic rd_s, wr_s, pin, sleep_cmd, ret_cmd;
  logic [31:0] wdata, rdata;
  logic bus_wait, sleep_s, instr_done, entry, ret_s, wake, vreq, push, restore, irq;
  logic [7:0] periph, acc, status, bank, pch, sh_acc, sh_status, sh_bank, sh_pch, d;
  logic [15:0] ptr, sh_ptr, seed;
  logic [14:0] ret_pc, push_pc;
  logic [3:0] lag;
  logic stepping = 1'b0; // Between a wake and the end of the following instruction.
  int fail_count = 0;
  int n_tests = 0;
  bit ok;

  irq_wake_ctrl i_dut (.sys_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(bus_wait), .ext_irq_pin_i(pin),
    .periph_req_i(periph), .sleep_i(sleep_s), .instr_done_i(instr_done), .entry_i(entry),
    .return_i(ret_s), .ret_pc_i(ret_pc), .acc_i(acc), .status_i(status), .bank_i(bank),
    .ptr_i(ptr), .pch_i(pch), .wake_o(wake), .vector_req_o(vreq), .push_o(push),
    .push_pc_o(push_pc), .restore_o(restore), .sh_acc_o(sh_acc), .sh_status_o(sh_status),
    .sh_bank_o(sh_bank), .sh_ptr_o(sh_ptr), .sh_pch_o(sh_pch), .irq_o(irq));

  core_model i_core (.clk_i(clk), .rstn_i(rstn), .wake_i(wake), .vector_req_i(vreq),
    .lag_i(lag), .sleep_cmd_i(sleep_cmd), .ret_cmd_i(ret_cmd), .sleep_o(sleep_s),
    .instr_done_o(instr_done), .entry_o(entry), .return_o(ret_s));

  // Free-running system clock, 50 ns period.
  always #25 clk = ~clk;

  // Sixteen-bit feedback shift register for repeatable random values.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Control register readback: bits 5 to 1 are not implemented.
  function automatic logic [7:0] exp_ctrl(input logic [7:0] w);
    return {w[7], w[6], 5'h00, w[0]};
  endfunction : exp_ctrl

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bus transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] wd);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, wd};
    wr_s <= w;
    rd_s <= !w;
    // Only the watchdog ends a wait for an answer that never comes.
    do
    begin
      @(posedge clk);
    end
    while (bus_wait !== 1'b0);
    d = rdata[7:0];
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : bus

  // Bounded wait for a one-cycle pulse: 0 push, 1 wake, 2 restore.
  task automatic wait_hi(input int sel, output bit got);
    got = 1'b0;
    for (int i = 0; i < 60 && !got; i++)
    begin
      @(posedge clk);
      got = (sel == 0) ? push === 1'b1 : (sel == 1) ? wake === 1'b1 : restore === 1'b1;
    end
  endtask : wait_hi

  // New random live context; the shadows must not follow it outside entry.
  task automatic load_ctx();
    seed = lfsr(seed);
    acc <= seed[7:0];
    status <= seed[15:8];
    seed = lfsr(seed);
    ptr <= seed;
    ret_pc <= seed[14:0] ^ 15'h2a5a;
    seed = lfsr(seed);
    bank <= seed[7:0];
    pch <= seed[15:8];
    lag <= seed[3:0] & 4'h7;
  endtask : load_ctx

  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // No vector request may appear while the post-wake instruction runs.
  always @(posedge clk)
  begin
    if (stepping && vreq !== 1'b0)
      chk("vector during step", 32'h0, {31'h0, vreq});
    stepping <= (wake === 1'b1) ? 1'b1 : (instr_done === 1'b1) ? 1'b0 : stepping;
  end

  // Cuts a hang short well beyond the few hundred cycles the run needs.
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial
  begin
    {rstn, addr, rd_s, wr_s, wdata, pin, sleep_cmd, ret_cmd, periph} = '0;
    {acc, status, bank, pch, ptr, ret_pc, lag} = '0;
    seed = 16'hc615;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, irq_pkg::ADDR_CTRL, 8'h00);
    chk("ctrl reset", 8'h01, d);
    bus(1'b1, irq_pkg::ADDR_CTRL, 8'hff);
    bus(1'b0, irq_pkg::ADDR_CTRL, 8'h00);
    chk("ctrl rw", exp_ctrl(8'hff), d);
    bus(1'b0, 6'h3c, 8'h00);
    chk("unmapped", 8'h00, d);
    // Both polarities: the selected edge sets the flag, the other does not.
    for (int s = 1; s >= 0; s--)
    begin
      bus(1'b1, irq_pkg::ADDR_CTRL, s[7:0]);
      pin <= !s[0];
      repeat (8) @(posedge clk);
      bus(1'b1, irq_pkg::ADDR_REQ0, 8'h00);
      pin <= s[0];
      repeat (8) @(posedge clk);
      bus(1'b0, irq_pkg::ADDR_REQ0, 8'h00);
      chk("flag on edge", 8'h01, d);
      bus(1'b1, irq_pkg::ADDR_REQ0, 8'h00);
      pin <= !s[0];
      repeat (8) @(posedge clk);
      bus(1'b0, irq_pkg::ADDR_REQ0, 8'h00);
      chk("flag wrong edge", 8'h00, d);
    end
    // Event status is sticky, masked, and cleared by writing ones.
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, irq_pkg::ADDR_MASK, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, irq_pkg::ADDR_EVT, 8'h0f);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Vectoring needs both the global and the pin enable.
    for (int k = 0; k < 4; k++)
    begin
      pin <= 1'b0;
      load_ctx();
      repeat (8) @(posedge clk);
      bus(1'b1, irq_pkg::ADDR_REQ0, 8'h00);
      bus(1'b1, irq_pkg::ADDR_EN0, {7'h00, k[0]});
      bus(1'b1, irq_pkg::ADDR_CTRL, {k[1], 6'h00, 1'b1});
      pin <= 1'b1;
      wait_hi(0, ok);
      chk("vector taken", {31'h0, k[1] & k[0]}, {31'h0, ok});
      if (k == 3)
      begin
        chk("push pc", ret_pc, push_pc);
        chk("sh acc st", {acc, status & irq_pkg::STATUS_SAVE_MASK}, {sh_acc, sh_status});
        chk("shadow ctx", {bank, ptr, pch}, {sh_bank, sh_ptr, sh_pch});
        d = bank;
        load_ctx();
        seed = lfsr(seed);
        bus(1'b1, irq_pkg::ADDR_SH_BANK, seed[7:0]);
        bus(1'b0, irq_pkg::ADDR_SH_BANK, 8'h00);
        chk("shadow rw", seed[7:0], d);
        bus(1'b1, irq_pkg::ADDR_REQ0, 8'h00);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        wait_hi(2, ok);
        chk("restore", {1'b1, seed[7:0]}, {ok, sh_bank});
      end
    end
    // Peripheral requests reach the core only with the peripheral enable.
    bus(1'b1, irq_pkg::ADDR_EN0, 8'h00);
    bus(1'b1, irq_pkg::ADDR_CTRL, 8'h81);
    periph <= seed[7:0] | 8'h10;
    repeat (10) @(posedge clk);
    chk("periph gated", 32'h0, {31'h0, vreq});
    bus(1'b1, irq_pkg::ADDR_CTRL, 8'hc1);
    wait_hi(0, ok);
    chk("periph vector", 32'h1, {31'h0, ok});
    periph <= 8'h00;
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    wait_hi(2, ok);
    // Wake from sleep, with and without the global enable.
    for (int g = 0; g < 2; g++)
    begin
      lag <= 4'h4;
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      bus(1'b1, irq_pkg::ADDR_EN0, 8'h01);
      bus(1'b1, irq_pkg::ADDR_REQ0, 8'h00);
      bus(1'b1, irq_pkg::ADDR_CTRL, {g[0], 6'h00, 1'b1});
      sleep_cmd <= 1'b1;
      @(posedge clk);
      sleep_cmd <= 1'b0;
      repeat (3) @(posedge clk);
      pin <= 1'b1;
      wait_hi(1, ok);
      chk("wake", 32'h1, {31'h0, ok});
      wait_hi(0, ok);
      chk("wake vector", {31'h0, g[0]}, {31'h0, ok});
      bus(1'b1, irq_pkg::ADDR_REQ0, 8'h00);
      ret_cmd <= g[0];
      @(posedge clk);
      ret_cmd <= 1'b0;
      repeat (4) @(posedge clk);
    end
    give_verdict();
  end
endmodule : tb
